// File: pkg/cel_pkg.sv
// Purpose: constants for the core exception latch
// Assumes: 32-bit avalon-mm register bus, word addressed by byte offset
package cel_pkg;
   localparam logic [3:0] CEL_OFS_LATCH = 4'h0;
   localparam logic [3:0] CEL_OFS_MODE = 4'h4;
   localparam logic [3:0] CEL_OFS_MASK = 4'h8;
   localparam logic [3:0] CEL_OFS_STAT = 4'hc;
   localparam int CEL_BIT_EMU = 0;
   localparam int CEL_BIT_RST = 1;
   localparam int CEL_BIT_PAR = 3;
   localparam int CEL_BIT_OPC = 4;
   localparam int CEL_BIT_CB7 = 5;
   localparam int CEL_BIT_ILL = 6;
   localparam int CEL_BIT_SPE = 27;
   localparam int CEL_BIT_DPE = 28;
   localparam int CEL_BIT_IPE = 29;
   localparam logic [6:0] CEL_RW_BITS = 7'h78;
   localparam logic [6:0] CEL_LATCH_RST = 7'h00;
   localparam logic [31:0] CEL_MODE_MASK = 32'h38000000;
   localparam logic [31:0] CEL_MODE_RST = 32'h00000000;
   localparam logic [6:0] CEL_MASK_RST = 7'h00;
   localparam logic [6:0] CEL_RSVD_BITS = 7'h04;
   localparam logic [6:0] CEL_FIXED_EN = 7'h03;
   localparam logic [1:0] CEL_KIND_I = 2'h0;
   localparam logic [1:0] CEL_KIND_D = 2'h1;
   localparam logic [1:0] CEL_KIND_S = 2'h2;
   localparam logic [2:0] CEL_SRC_EMU = 3'h1;
   localparam logic [2:0] CEL_SRC_RST = 3'h2;
   localparam logic [2:0] CEL_SRC_PAR = 3'h3;
   localparam logic [2:0] CEL_SRC_OPC = 3'h4;
   localparam logic [2:0] CEL_SRC_CB7 = 3'h5;
   localparam logic [2:0] CEL_SRC_ILL = 3'h6;
   localparam logic [2:0] CEL_SRC_NONE = 3'h0;
endpackage

// File: rtl/cel_sync.sv
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: async input, one clock
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module cel_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic sync_out
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            sync_out <= s3;
         end
      end
   end
endmodule

// File: rtl/cel_top.sv
// Purpose: pending exception latch with mode, mask and avalon-mm slave
// Assumes: core event inputs are single-cycle pulses on clk
// Notes: the reset pin arrives asynchronously and is synchronised
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module cel_top
   import cel_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic illegal_ioreg_access_flag,
   input wire logic unaligned_wide_access_flag,
   input wire logic circ_buf7_wrap,
   input wire logic bad_opcode_fetch,
   input wire logic l1_access_valid,
   input wire logic l1_access_abort,
   input wire logic [1:0] l1_access_kind,
   input wire logic l1_parity_mismatch,
   input wire logic hw_reset_pin,
   input wire logic reset_controller_soft_reset,
   input wire logic emu_request,
   input wire logic emu_breakpoint,
   output logic irq,
   output logic [2:0] irq_source,
   output logic instr_parity_check_en,
   output logic data_parity_check_en,
   output logic sys_xfer_parity_check_en
);
   logic [6:0] interrupt_latch_reg;
   logic [31:0] mode_control_reg;
   logic [6:0] mask_reg;
   logic answered;
   logic [31:0] next_readdata;
   logic [6:0] next_latch;
   logic hw_pin_sync;
   logic hw_pin_prev;

   cel_sync u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(hw_reset_pin),
      .sync_out(hw_pin_sync)
   );

   // one-cycle stall on every access, answer on the second cycle
   wire access = avs_read | avs_write;
   assign avs_waitrequest = access & ~answered;
   wire take = access & answered;
   wire wr_take = take & avs_write;
   wire sel_latch = avs_address == CEL_OFS_LATCH;
   wire sel_mode = avs_address == CEL_OFS_MODE;
   wire sel_mask = avs_address == CEL_OFS_MASK;
   wire sel_stat = avs_address == CEL_OFS_STAT;
   wire be0 = avs_byteenable[0];
   wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{be0}}};

   wire sel_kind_i = l1_access_kind == CEL_KIND_I;
   wire sel_kind_d = l1_access_kind == CEL_KIND_D;
   wire sel_kind_s = l1_access_kind == CEL_KIND_S;
   wire kind_enabled = (sel_kind_i & instr_parity_check_en)
                     | (sel_kind_d & data_parity_check_en)
                     | (sel_kind_s & sys_xfer_parity_check_en);
   wire par_event = l1_access_valid & ~l1_access_abort & kind_enabled & l1_parity_mismatch;
   wire ill_event = illegal_ioreg_access_flag | unaligned_wide_access_flag;
   wire hw_pin_rise = hw_pin_sync & ~hw_pin_prev;
   wire rst_event = hw_pin_rise | reset_controller_soft_reset;
   wire emu_event = emu_request | emu_breakpoint;

   wire [6:0] hw_set;
   assign hw_set[CEL_BIT_EMU] = emu_event;
   assign hw_set[CEL_BIT_RST] = rst_event;
   assign hw_set[2] = 1'b0;
   assign hw_set[CEL_BIT_PAR] = par_event;
   assign hw_set[CEL_BIT_OPC] = bad_opcode_fetch;
   assign hw_set[CEL_BIT_CB7] = circ_buf7_wrap;
   assign hw_set[CEL_BIT_ILL] = ill_event;

   // software replaces bits 6..3 only; a same-cycle hardware set wins
   wire latch_wr = wr_take & sel_latch & be0;
   wire [6:0] sw_val = (interrupt_latch_reg & ~CEL_RW_BITS) | (avs_writedata[6:0] & CEL_RW_BITS);
   wire [6:0] base_val = latch_wr ? sw_val : interrupt_latch_reg;
   assign next_latch = (base_val | hw_set) & ~CEL_RSVD_BITS;

   // status-clear view: write one to clear, emulator and reset bits included
   wire stat_wr = wr_take & sel_stat & be0;
   wire [6:0] stat_clr = stat_wr ? avs_writedata[6:0] : 7'h00;

   // one flop per latch bit; a same-cycle set beats the status clear
   genvar gb;
   generate
      for (gb = 0; gb < 7; gb++) begin : g_latch
         wire bit_clr = stat_clr[gb] & ~hw_set[gb];
         wire next_bit = next_latch[gb] & ~bit_clr & ~CEL_RSVD_BITS[gb];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               interrupt_latch_reg[gb] <= CEL_LATCH_RST[gb];
            end else begin
               interrupt_latch_reg[gb] <= next_bit;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_control_reg <= CEL_MODE_RST;
      end else if (wr_take & sel_mode) begin
         mode_control_reg <= (mode_control_reg & ~be_mask) | (avs_writedata & be_mask & CEL_MODE_MASK);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= CEL_MASK_RST;
      end else if (wr_take & sel_mask & be0) begin
         mask_reg <= avs_writedata[6:0] & CEL_RW_BITS;
      end
   end

   assign instr_parity_check_en = mode_control_reg[CEL_BIT_IPE];
   assign data_parity_check_en = mode_control_reg[CEL_BIT_DPE];
   assign sys_xfer_parity_check_en = mode_control_reg[CEL_BIT_SPE];

   // reset and emulator bits are always enabled
   wire [6:0] eff_mask = mask_reg | CEL_FIXED_EN;
   wire [6:0] active = interrupt_latch_reg & eff_mask;

   // fixed priority, emulator first, then by bit number upward
   logic [2:0] next_source;
   always_comb begin
      next_source = CEL_SRC_NONE;
      if (active[CEL_BIT_EMU]) begin
         next_source = CEL_SRC_EMU;
      end else if (active[CEL_BIT_RST]) begin
         next_source = CEL_SRC_RST;
      end else if (active[CEL_BIT_PAR]) begin
         next_source = CEL_SRC_PAR;
      end else if (active[CEL_BIT_OPC]) begin
         next_source = CEL_SRC_OPC;
      end else if (active[CEL_BIT_CB7]) begin
         next_source = CEL_SRC_CB7;
      end else if (active[CEL_BIT_ILL]) begin
         next_source = CEL_SRC_ILL;
      end
   end

   wire [31:0] rd_latch = {25'h0, interrupt_latch_reg};
   wire [31:0] rd_mask = {25'h0, eff_mask};
   always_comb begin
      next_readdata = 32'h0;
      if (sel_latch | sel_stat) begin
         next_readdata = rd_latch;
      end else if (sel_mode) begin
         next_readdata = mode_control_reg;
      end else if (sel_mask) begin
         next_readdata = rd_mask;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         answered <= 1'b0;
         avs_readdata <= 32'h0;
         irq <= 1'b0;
         irq_source <= CEL_SRC_NONE;
         hw_pin_prev <= 1'b0;
      end else begin
         answered <= access & ~answered;
         if (access & ~answered & avs_read) begin
            avs_readdata <= next_readdata;
         end
         irq <= |active;
         irq_source <= next_source;
         hw_pin_prev <= hw_pin_sync;
      end
   end
endmodule

// File: tb/cel_props.sv
// Purpose: port checks for cel_top
// Assumes: cel_pkg constants, mode writes use all byte lanes
// Notes: bound from the bench top
`timescale 1ns/1ps
module cel_props
   import cel_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic hw_reset_pin,
   input wire logic reset_controller_soft_reset,
   input wire logic emu_request,
   input wire logic emu_breakpoint,
   input wire logic irq,
   input wire logic [2:0] irq_source,
   input wire logic instr_parity_check_en,
   input wire logic data_parity_check_en,
   input wire logic sys_xfer_parity_check_en
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire mode_wr = avs_write && !avs_waitrequest && avs_address == CEL_OFS_MODE;
   wire [2:0] en = {instr_parity_check_en, data_parity_check_en, sys_xfer_parity_check_en};
   sequence s_stall; avs_waitrequest ##1 !avs_waitrequest; endsequence
   sequence s_emu_won; ##1 irq && irq_source == CEL_SRC_EMU; endsequence
   property p_emu_req; emu_request |=> s_emu_won; endproperty
   a_emu_req: assert property (p_emu_req) else $error("emulator request lost");
   property p_emu_bkp; emu_breakpoint |=> s_emu_won; endproperty
   a_emu_bkp: assert property (p_emu_bkp) else $error("breakpoint lost");
   property p_soft; reset_controller_soft_reset |=> ##1 irq; endproperty
   a_soft: assert property (p_soft) else $error("soft reset lost");
   property p_hw; $rose(hw_reset_pin) |-> ##[2:10] irq; endproperty
   a_hw: assert property (p_hw) else $error("reset pin lost");
   property p_mode; mode_wr |=> en == $past(avs_writedata[29:27]); endproperty
   a_mode: assert property (p_mode) else $error("parity enables not written");
   property p_hold; !mode_wr |=> $stable(en); endproperty
   a_hold: assert property (p_hold) else $error("parity enables moved");
   property p_src; irq_source == CEL_SRC_EMU |-> irq; endproperty
   a_src: assert property (p_src) else $error("emulator source without irq");
   property p_wait; $rose(avs_read || avs_write) |-> s_stall; endproperty
   a_wait: assert property (p_wait) else $error("waitrequest timing");
endmodule

// File: tb/cel_src_model.sv
// Purpose: core event source model
// Assumes: bench holds each event bit for the cycles wanted
// Notes: bits 12..11 carry the access kind
`timescale 1ns/1ps
module cel_src_model (
   input wire logic clk,
   input wire logic [12:0] ev,
   output logic [12:0] pulse
);
   initial pulse = 13'h0;
   // every event bit is registered and reaches the core one clock later
   always @(posedge clk) pulse <= ev;
endmodule

// File: tb/core_exception_latch_tb.sv
// Purpose: self-checking bench for cel_top
// Assumes: 50 ns clock, two idle cycles between bus accesses
// Notes: reads queue their expected word, a monitor compares
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module core_exception_latch_tb;
   import cel_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
   logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0, r, e;
   logic [12:0] ev = 13'h0;
   logic [31:0] q[$];
   logic [23:0] tbl[13] = '{24'hf80140, 24'hf80240, 24'hf80420, 24'hf80810, 24'h805008, 24'h485008, 24'h305008,
      24'h405000, 24'he07000, 24'hf88002, 24'hf90001, 24'hfa0001, 24'hfc0002};
   wire avs_waitrequest, irq, instr_parity_check_en, data_parity_check_en, sys_xfer_parity_check_en;
   wire [2:0] irq_source;
   wire [31:0] avs_readdata;
   wire [12:0] p;
   int fail_count = 0, n_compared = 0, seed = 32'hb3b46630;
   always #25 clk = ~clk;
   cel_src_model u_cel_src_model(.clk(clk), .ev(ev), .pulse(p));
   cel_top u_cel_top(.*, .illegal_ioreg_access_flag(p[0]), .unaligned_wide_access_flag(p[1]), .circ_buf7_wrap(p[2]),
      .bad_opcode_fetch(p[3]), .l1_access_valid(p[4]), .l1_access_abort(p[5]), .l1_parity_mismatch(p[6]),
      .reset_controller_soft_reset(p[7]), .emu_request(p[8]), .emu_breakpoint(p[9]), .hw_reset_pin(p[10]),
      .l1_access_kind(p[12:11]));
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      repeat (2) @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      q.push_back(x);
      bus(1'h0, a, 32'h0);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(negedge clk) if (avs_read && avs_waitrequest === 1'h0) begin
      e = q.pop_front();
      `CHK("readdata", e, avs_readdata)
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      rd(CEL_OFS_LATCH, 32'h0);
      rd(CEL_OFS_MASK, 32'h3);
      rd(4'h2, 32'h0);
      foreach (tbl[i]) begin
         bus(1'h1, CEL_OFS_MODE, {2'h0, tbl[i][23:21], 27'h0});
         `CHK("enables", tbl[i][23:21], {instr_parity_check_en, data_parity_check_en, sys_xfer_parity_check_en})
         ev <= tbl[i][20:8];
         @(posedge clk);
         // kind and reset pin stay up for the pin filter
         ev <= tbl[i][20:8] & 13'h1c00;
         repeat (5) @(posedge clk);
         ev <= 13'h0;
         repeat (4) @(posedge clk);
         rd(CEL_OFS_LATCH, {25'h0, tbl[i][6:0]});
         `CHK("irq", |tbl[i][1:0], irq)
         bus(1'h1, CEL_OFS_STAT, 32'h7f);
         $display("event test %0d done", i);
      end
      bus(1'h1, CEL_OFS_LATCH, 32'h7f);
      rd(CEL_OFS_LATCH, 32'h78);
      bus(1'h1, CEL_OFS_MASK, 32'h8);
      `CHK("source", CEL_SRC_PAR, irq_source)
      repeat (4) begin
         r = $random(seed);
         bus(1'h1, CEL_OFS_LATCH, r);
         rd(CEL_OFS_LATCH, {25'h0, r[6:3], 3'h0});
         `CHK("masked irq", r[3], irq)
      end
      $display("register test done");
      report_and_stop();
   end
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
bind cel_top cel_props u_cel_props(.*);
